// ===== cpp_device.sv
// accelerator end: clock source, pin function and power pin control
//
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/10ps
module cpp_device
	import cpp_pkg::*;
(
	input wire logic CLOCK_IN,
	input wire logic RSTN_IN,
	cpp_link_if.device LINK,
	input wire logic MEM_SYNTH_CLOCK_IN,
	input wire logic VID_SYNTH_CLOCK_IN,
	input wire logic SUBCARRIER_REF_IN,
	input wire logic [3:0] PANEL_ID_PINS_IN,
	input wire logic STANDBY_PIN_IN,
	input wire logic SHIFT_CLOCK_IN,
	input wire logic BACKLIGHT_POWER_IN,
	output logic MEM_CLOCK_OUT,
	output logic VID_CLOCK_OUT,
	output logic SYNTH_ENABLE_OUT,
	output logic SUBCARRIER_OUT,
	output logic ENCODING_SELECT_OUT,
	output logic SECOND_SHIFT_CLOCK_OUT,
	output logic BACKLIGHT_CONTROL_OUT,
	output logic STANDBY_PIN_OUT,
	output logic STANDBY_PIN_OE_OUT,
	output logic LOW_POWER_OUT,
	output logic SPREAD_REFERENCE_OUT
);
	typedef struct packed {
		logic [7:0] pin_function_reg;
		logic [7:0] subcarrier_config_reg;
		logic [7:0] bus_feature_reg;
		logic [7:0] panel_id_reg;
		logic [7:0] general_output_reg;
		logic [7:0] pin_direction_reg;
		logic [7:0] control_reg;
		logic hw_suspend;
		logic [1:0] id_wait;
		logic [2:0] fsc_count;
		logic subcarrier;
		logic [7:0] rdata;
		logic done;
		logic clkrun_drive;
	} cpp_dev_type;
	cpp_dev_type state;
	cpp_dev_type next_state;
	logic [7:0] async_sync;
	logic [3:0] id_sync;
	logic sub_ref_level;
	logic source_external;
	logic suspend_level;
	logic [1:0] pins_sync;
	logic standby_level;
	logic [7:0] general_status;
	logic [7:0] power_status;
	// asynchronous pins pass two flip-flops before use
	// panel id and subcarrier reference ride along; only the bus grant and clock run lines reach logic raw
	cpp_sync2 #(.WIDTH(8)) u_sync (
		.clock_in(CLOCK_IN),
		.rstn_in(RSTN_IN),
		.async_in({LINK.clock_source_select, LINK.suspend_line, STANDBY_PIN_IN,
			SUBCARRIER_REF_IN, PANEL_ID_PINS_IN}),
		.sync_out(async_sync)
	);
	cpp_sync2 #(.WIDTH(2)) u_sync_pins (
		.clock_in(CLOCK_IN),
		.rstn_in(RSTN_IN),
		.async_in({LINK.memory_clock_line, LINK.video_clock_line}),
		.sync_out(pins_sync)
	);
	assign source_external = async_sync[7];
	assign suspend_level = async_sync[6] && !state.pin_direction_reg[PD_SUSPEND_DIR_BIT];
	assign standby_level = state.pin_direction_reg[PD_STANDBY_DIR_BIT] ?
		state.control_reg[CT_STANDBY_BIT] : async_sync[5];
	assign sub_ref_level = async_sync[4];
	assign id_sync = async_sync[3:0];
	// status views of the pins
	always_comb begin
		general_status = RESET_BYTE;
		general_status[GS_STATUS4_BIT] = pins_sync[1] && state.pin_function_reg[PF_MEM_PIN_BIT];
		general_status[GS_STATUS3_BIT] = pins_sync[0] && state.pin_function_reg[PF_VID_PIN_BIT];
		power_status = RESET_BYTE;
		power_status[PS_STANDBY_BIT] = standby_level;
	end
	// register file, suspend, subcarrier divider and clockrun
	always_comb begin
		next_state = state;
		next_state.done = 1'b0;
		// panel id follows the pins for the first edges after reset, later on request;
		// the wait covers both synchroniser stages so reset zeros are never kept
		if (state.id_wait != ID_SETTLE_CYCLES || state.pin_function_reg[PF_ID_SAMPLE_BIT]) begin
			next_state.panel_id_reg = {4'h0, id_sync};
		end
		if (state.id_wait != ID_SETTLE_CYCLES) begin
			next_state.id_wait = state.id_wait + 2'h1;
		end
		// hardware suspend follows the input level both ways
		next_state.hw_suspend = suspend_level;
		next_state.control_reg[CT_HW_SUSPEND_BIT] = suspend_level;
		next_state.control_reg[CT_GRANT_BIT] = !LINK.bus_grant_n;
		// register accesses are ignored while in hardware suspend
		if (LINK.reg_sel && !state.done && !state.hw_suspend) begin
			next_state.done = 1'b1;
			if (LINK.reg_write) begin
				case (LINK.reg_addr)
					REG_PIN_FUNCTION: next_state.pin_function_reg = LINK.reg_wdata;
					REG_SUBCARRIER_CONFIG: next_state.subcarrier_config_reg = LINK.reg_wdata;
					REG_BUS_FEATURE: next_state.bus_feature_reg = LINK.reg_wdata;
					REG_GENERAL_OUTPUT: next_state.general_output_reg = LINK.reg_wdata;
					REG_PIN_DIRECTION: next_state.pin_direction_reg = LINK.reg_wdata;
					REG_CONTROL: next_state.control_reg[CT_BUSY_BIT:0] = LINK.reg_wdata[CT_BUSY_BIT:0];
					default: next_state.done = 1'b1;
				endcase
			end else begin
				case (LINK.reg_addr)
					REG_GENERAL_STATUS: next_state.rdata = general_status;
					REG_PIN_FUNCTION: next_state.rdata = state.pin_function_reg;
					REG_SUBCARRIER_CONFIG: next_state.rdata = state.subcarrier_config_reg;
					REG_BUS_FEATURE: next_state.rdata = state.bus_feature_reg;
					REG_PANEL_ID: next_state.rdata = state.panel_id_reg;
					REG_GENERAL_OUTPUT: next_state.rdata = state.general_output_reg;
					REG_PIN_DIRECTION: next_state.rdata = state.pin_direction_reg;
					REG_POWER_STATUS: next_state.rdata = power_status;
					REG_CONTROL: next_state.rdata = state.control_reg;
					default: next_state.rdata = RESET_BYTE;
				endcase
			end
		end
		// subcarrier divided from the reference, sampled on the bus clock
		if (state.fsc_count == 3'h0) begin
			next_state.subcarrier = !state.subcarrier;
			next_state.fsc_count = state.subcarrier_config_reg[SC_FOURX_BIT] ? 3'h0 : FSC_DIV_ONEX;
		end else begin
			next_state.fsc_count = state.fsc_count - 3'h1;
		end
		if (!sub_ref_level) begin
			next_state.fsc_count = state.fsc_count;
			next_state.subcarrier = state.subcarrier;
		end
		// clockrun held low while enabled and work pending
		next_state.clkrun_drive = state.bus_feature_reg[BF_CLKRUN_EN_BIT] &&
			state.control_reg[CT_BUSY_BIT] && (LINK.clkrun_line || state.clkrun_drive);
	end
	always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end
	// clock pins: memory pin driven only in internal mode, video pin also in external mode with spread set
	assign LINK.memory_clock_pin_dev_o = MEM_SYNTH_CLOCK_IN;
	assign LINK.memory_clock_pin_dev_oe = !source_external && !state.pin_function_reg[PF_MEM_PIN_BIT]
		&& !state.pin_function_reg[PF_SPREAD_BIT];
	assign LINK.video_clock_pin_dev_o = state.pin_function_reg[PF_SPREAD_BIT] ?
		VID_SYNTH_CLOCK_IN : VID_SYNTH_CLOCK_IN;
	assign LINK.video_clock_pin_dev_oe = (!source_external || state.pin_function_reg[PF_SPREAD_BIT])
		&& !state.pin_function_reg[PF_VID_PIN_BIT];
	// clock choice: synthesizers off in external mode
	assign SYNTH_ENABLE_OUT = !source_external && !state.hw_suspend;
	assign MEM_CLOCK_OUT = (source_external || state.pin_function_reg[PF_SPREAD_BIT]) ?
		LINK.memory_clock_line : MEM_SYNTH_CLOCK_IN;
	assign VID_CLOCK_OUT = source_external ? LINK.video_clock_line : VID_SYNTH_CLOCK_IN;
	assign SPREAD_REFERENCE_OUT = state.pin_function_reg[PF_SPREAD_BIT];
	assign SUBCARRIER_OUT = state.subcarrier;
	assign ENCODING_SELECT_OUT = state.control_reg[CT_PAL_BIT];
	// both bits zero hand the pin to its normal source, else the low bit drives it
	function automatic logic general_pin(input logic [1:0] field, input logic normal);
		return (field == 2'h0) ? normal : field[0];
	endfunction : general_pin
	assign SECOND_SHIFT_CLOCK_OUT =
		general_pin(state.general_output_reg[1:0], SHIFT_CLOCK_IN);
	assign BACKLIGHT_CONTROL_OUT =
		general_pin(state.general_output_reg[3:2], BACKLIGHT_POWER_IN);
	assign STANDBY_PIN_OUT = state.control_reg[CT_STANDBY_BIT];
	assign STANDBY_PIN_OE_OUT = state.pin_direction_reg[PD_STANDBY_DIR_BIT];
	assign LOW_POWER_OUT = state.hw_suspend;
	// suspend pin as output shows software suspend
	assign LINK.suspend_dev_o = state.control_reg[CT_SW_SUSPEND_BIT];
	assign LINK.suspend_dev_oe = state.pin_direction_reg[PD_SUSPEND_DIR_BIT];
	assign LINK.interrupt_n_oe = state.control_reg[CT_IRQ_BIT];
	assign LINK.bus_request_n_o = !state.control_reg[CT_BUSREQ_BIT];
	assign LINK.bus_request_n_oe = 1'b1;
	assign LINK.clkrun_dev_oe = state.clkrun_drive;
	assign LINK.reg_rdata = state.rdata;
	assign LINK.reg_done = state.done;
endmodule : cpp_device

// ===== cpp_pkg.sv
// package with register offsets, field positions, reset values and timing counts
package cpp_pkg;
	// device register indices (reached through the device's own interface)
	localparam logic [3:0] REG_GENERAL_STATUS = 4'h1;
	localparam logic [3:0] REG_PIN_FUNCTION = 4'h2;
	localparam logic [3:0] REG_SUBCARRIER_CONFIG = 4'h3;
	localparam logic [3:0] REG_BUS_FEATURE = 4'h4;
	localparam logic [3:0] REG_PANEL_ID = 4'h5;
	localparam logic [3:0] REG_GENERAL_OUTPUT = 4'h6;
	localparam logic [3:0] REG_PIN_DIRECTION = 4'h7;
	localparam logic [3:0] REG_POWER_STATUS = 4'h8;
	localparam logic [3:0] REG_CONTROL = 4'h9;
	// field positions
	localparam int GS_STATUS4_BIT = 1;
	localparam int GS_STATUS3_BIT = 2;
	localparam int PF_MEM_PIN_BIT = 0;
	localparam int PF_VID_PIN_BIT = 1;
	localparam int PF_ID_SAMPLE_BIT = 3;
	localparam int PF_SPREAD_BIT = 7;
	localparam int SC_FOURX_BIT = 5;
	localparam int BF_CLKRUN_EN_BIT = 5;
	localparam int PD_STANDBY_DIR_BIT = 3;
	localparam int PD_SUSPEND_DIR_BIT = 4;
	localparam int PS_STANDBY_BIT = 5;
	localparam int CT_STANDBY_BIT = 0;
	localparam int CT_SW_SUSPEND_BIT = 1;
	localparam int CT_PAL_BIT = 2;
	localparam int CT_IRQ_BIT = 3;
	localparam int CT_BUSREQ_BIT = 4;
	localparam int CT_BUSY_BIT = 5;
	localparam int CT_HW_SUSPEND_BIT = 6;
	localparam int CT_GRANT_BIT = 7;
	// reset values
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// subcarrier divider: four-times output is the reference halved, one-times is /8
	localparam logic [2:0] FSC_DIV_ONEX = 3'h3;
	// edges after reset during which the panel id follows its synchronised pins
	localparam logic [1:0] ID_SETTLE_CYCLES = 2'h3;
	// avalon register offsets of the host controller (word addresses)
	localparam logic [1:0] AV_CMD = 2'h0;
	localparam logic [1:0] AV_WDATA = 2'h1;
	localparam logic [1:0] AV_STATUS = 2'h2;
	localparam logic [1:0] AV_RDATA = 2'h3;
	localparam int AV_CMD_WRITE_BIT = 4;
	localparam int AV_CMD_GO_BIT = 5;
	localparam int AV_CMD_GRANT_BIT = 6;
	localparam int AV_CMD_SUSPEND_BIT = 7;
	localparam int AV_CMD_XCLK_BIT = 8;
	localparam int AV_CMD_CLKSTOP_BIT = 9;
	localparam int AV_CMD_HELD_BIT = 10;
	// register access takes this many link cycles per phase
	localparam logic [1:0] ACCESS_CYCLES = 2'h2;
endpackage : cpp_pkg

// ===== cpp_link_if.sv
// interface joining the accelerator pin control and its host
`timescale 1ns/10ps
interface cpp_link_if;
	logic clock_source_select;
	logic suspend_dev_o;
	logic suspend_dev_oe;
	logic suspend_host_o;
	logic suspend_host_oe;
	logic suspend_line;
	logic bus_request_n_o;
	logic bus_request_n_oe;
	logic bus_grant_n;
	logic interrupt_n_oe;
	logic clkrun_dev_oe;
	logic clkrun_host_oe;
	logic clkrun_line;
	logic memory_clock_pin_host_o;
	logic memory_clock_pin_host_oe;
	logic video_clock_pin_host_o;
	logic video_clock_pin_host_oe;
	logic memory_clock_pin_dev_o;
	logic memory_clock_pin_dev_oe;
	logic video_clock_pin_dev_o;
	logic video_clock_pin_dev_oe;
	logic memory_clock_line;
	logic video_clock_line;
	logic reg_sel;
	logic reg_write;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic reg_done;
	// wire resolution; open drain lines float high, a pull-up is implied
	assign suspend_line = suspend_dev_oe ? suspend_dev_o : (suspend_host_oe ? suspend_host_o : 1'b0);
	assign clkrun_line = !(clkrun_dev_oe || clkrun_host_oe);
	assign memory_clock_line = memory_clock_pin_dev_oe ? memory_clock_pin_dev_o :
		(memory_clock_pin_host_oe ? memory_clock_pin_host_o : 1'b0);
	assign video_clock_line = video_clock_pin_dev_oe ? video_clock_pin_dev_o :
		(video_clock_pin_host_oe ? video_clock_pin_host_o : 1'b0);
	modport device (
		input clock_source_select, suspend_line, bus_grant_n, clkrun_line,
		input memory_clock_line, video_clock_line,
		output suspend_dev_o, suspend_dev_oe, bus_request_n_o, bus_request_n_oe,
		output interrupt_n_oe, clkrun_dev_oe,
		output memory_clock_pin_dev_o, memory_clock_pin_dev_oe,
		output video_clock_pin_dev_o, video_clock_pin_dev_oe,
		input reg_sel, reg_write, reg_addr, reg_wdata,
		output reg_rdata, reg_done
	);
	modport host (
		output clock_source_select, suspend_host_o, suspend_host_oe, bus_grant_n,
		output clkrun_host_oe, memory_clock_pin_host_o, memory_clock_pin_host_oe,
		output video_clock_pin_host_o, video_clock_pin_host_oe,
		input suspend_line, bus_request_n_o, bus_request_n_oe, interrupt_n_oe, clkrun_line,
		output reg_sel, reg_write, reg_addr, reg_wdata,
		input reg_rdata, reg_done
	);
endinterface : cpp_link_if

// ===== cpp_sync2.sv
// two flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/10ps
module cpp_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic clock_in,
	input wire logic rstn_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} cpp_sync_type;
	cpp_sync_type state;
	cpp_sync_type next_state;
	// first stage feeds only the second stage
	always_comb begin
		next_state = state;
		next_state.first = async_in;
		next_state.second = state.first;
	end
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end
	assign sync_out = state.second;
endmodule : cpp_sync2

// ===== cpp_host.sv
// host end: arbiter, reset owner, clock resource and register access over avalon
`timescale 1ns/10ps
module cpp_host
	import cpp_pkg::*;
(
	input wire logic CLOCK_IN,
	input wire logic RSTN_IN,
	cpp_link_if.host LINK,
	input wire logic EXT_MEM_CLOCK_IN,
	input wire logic EXT_VID_CLOCK_IN,
	input wire logic [1:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [31:0] AVS_WRITEDATA_IN,
	output logic [31:0] AVS_READDATA_OUT,
	output logic AVS_WAITREQUEST_OUT,
	output logic DEVICE_RSTN_OUT
);
	typedef enum {IDLE, ACCESS, ANSWER} cpp_host_state_type;
	typedef struct packed {
		cpp_host_state_type fsm;
		logic [10:0] cmd;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic busy;
		logic [31:0] readdata;
		logic ack;
		logic rstn;
	} cpp_host_type;
	cpp_host_type state;
	cpp_host_type next_state;
	logic [3:0] pin_sync;
	cpp_sync2 #(.WIDTH(4)) u_sync (
		.clock_in(CLOCK_IN),
		.rstn_in(RSTN_IN),
		.async_in({LINK.suspend_line, !LINK.bus_request_n_o && LINK.bus_request_n_oe,
			LINK.interrupt_n_oe, !LINK.clkrun_line}),
		.sync_out(pin_sync)
	);
	// avalon slave, one access fsm toward the device register port
	always_comb begin
		next_state = state;
		next_state.ack = 1'b0;
		next_state.rstn = 1'b1;
		case (state.fsm)
			IDLE: begin
				if (state.busy) begin
					next_state.fsm = ACCESS;
				end
			end
			ACCESS: begin
				if (LINK.reg_done) begin
					next_state.rdata = LINK.reg_rdata;
					next_state.busy = 1'b0;
					next_state.fsm = IDLE;
				end
			end
			default: next_state.fsm = IDLE;
		endcase
		if ((AVS_READ_IN || AVS_WRITE_IN) && !state.ack) begin
			next_state.ack = 1'b1;
		end
		// a write lands at the edge where the master sees waitrequest low, not before
		if (AVS_WRITE_IN && state.ack) begin
			case (AVS_ADDRESS_IN)
				AV_CMD: begin
					next_state.cmd = AVS_WRITEDATA_IN[10:0];
					// keeps a completion in the same cycle from being lost
					next_state.busy = AVS_WRITEDATA_IN[AV_CMD_GO_BIT] || next_state.busy;
				end
				AV_WDATA: next_state.wdata = AVS_WRITEDATA_IN[7:0];
				default: next_state.wdata = state.wdata;
			endcase
		end
		// read data is latched one edge early so it stands when waitrequest drops
		if (AVS_READ_IN && !state.ack) begin
			case (AVS_ADDRESS_IN)
				AV_CMD: next_state.readdata = {21'h0, state.cmd};
				AV_WDATA: next_state.readdata = {24'h0, state.wdata};
				AV_STATUS: next_state.readdata = {27'h0, state.busy, pin_sync};
				AV_RDATA: next_state.readdata = {24'h0, state.rdata};
				default: next_state.readdata = 32'h0000_0000;
			endcase
		end
	end
	always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end
	assign AVS_WAITREQUEST_OUT = !state.ack;
	assign AVS_READDATA_OUT = state.readdata;
	// device reset follows our own reset
	assign DEVICE_RSTN_OUT = state.rstn;
	assign LINK.reg_sel = state.fsm == ACCESS;
	assign LINK.reg_write = state.cmd[AV_CMD_WRITE_BIT];
	assign LINK.reg_addr = state.cmd[3:0];
	assign LINK.reg_wdata = state.wdata;
	// grant on command
	assign LINK.bus_grant_n = !state.cmd[AV_CMD_GRANT_BIT];
	// external clocks and suspend
	assign LINK.clock_source_select = state.cmd[AV_CMD_XCLK_BIT];
	assign LINK.memory_clock_pin_host_o = EXT_MEM_CLOCK_IN;
	assign LINK.memory_clock_pin_host_oe = state.cmd[AV_CMD_XCLK_BIT];
	assign LINK.video_clock_pin_host_o = EXT_VID_CLOCK_IN;
	assign LINK.video_clock_pin_host_oe = state.cmd[AV_CMD_XCLK_BIT];
	assign LINK.suspend_host_o = state.cmd[AV_CMD_SUSPEND_BIT];
	assign LINK.suspend_host_oe = state.cmd[AV_CMD_SUSPEND_BIT];
	assign LINK.clkrun_host_oe = state.cmd[AV_CMD_HELD_BIT];
endmodule : cpp_host

// ===== cpp_link_assertions.sv
// link checker: timing relations between the host end and the accelerator end
`timescale 1ns/10ps
module cpp_link_assertions (
	input wire logic clock_in,
	input wire logic rstn_in,
	input wire logic clock_source_select,
	input wire logic suspend_dev_oe,
	input wire logic suspend_line,
	input wire logic bus_request_n_o,
	input wire logic bus_request_n_oe,
	input wire logic interrupt_n_oe,
	input wire logic clkrun_dev_oe,
	input wire logic clkrun_line,
	input wire logic memory_clock_pin_host_oe,
	input wire logic video_clock_pin_host_oe,
	input wire logic memory_clock_pin_dev_oe,
	input wire logic video_clock_pin_dev_oe,
	input wire logic reg_sel,
	input wire logic reg_done
);
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rstn_in);
	// select held long enough to have passed the two-stage synchroniser
	sequence ext_settled;
		clock_source_select [*4];
	endsequence
	// suspend driven in by the host, not the device echoing its own status
	sequence hw_suspend_held;
		(suspend_line && !suspend_dev_oe) [*3];
	endsequence
	sequence access_start;
		$rose(reg_sel) && !suspend_line;
	endsequence
	AST_BUSREQ_DRIVEN: assert property (!bus_request_n_o |-> bus_request_n_oe)
		else $error("bus request low but not driven");
	AST_DONE_PULSE: assert property (reg_done |=> !reg_done)
		else $error("register done longer than one cycle");
	AST_ACCESS_ANSWERED: assert property (access_start |-> ##[1:8] reg_done)
		else $error("register access not answered");
	AST_EXT_RELEASES_PINS: assert property (ext_settled
		|-> !memory_clock_pin_dev_oe && !video_clock_pin_dev_oe)
		else $error("device drives a clock pin in external mode");
	AST_HOST_DRIVES_EXT: assert property (ext_settled
		|-> memory_clock_pin_host_oe && video_clock_pin_host_oe)
		else $error("host leaves a clock pin undriven in external mode");
	AST_SELECT_SYNC_RISE: assert property ($rose(clock_source_select)
		&& (memory_clock_pin_dev_oe || video_clock_pin_dev_oe)
		|=> memory_clock_pin_dev_oe || video_clock_pin_dev_oe)
		else $error("select acted on without synchronising");
	AST_SELECT_SYNC_FALL: assert property ($fell(clock_source_select)
		&& !memory_clock_pin_dev_oe && !video_clock_pin_dev_oe
		|=> !memory_clock_pin_dev_oe && !video_clock_pin_dev_oe)
		else $error("select release acted on without synchronising");
	AST_CLKRUN_SAMPLED: assert property ($rose(clkrun_dev_oe) |-> $past(clkrun_line))
		else $error("clock run pulled without sampling it high");
	AST_IRQ_LEVEL: assert property ($rose(interrupt_n_oe) |-> interrupt_n_oe [*4])
		else $error("interrupt not held as a level");
	AST_SUSPEND_BLOCKS_ACCESS: assert property (hw_suspend_held |-> !reg_done)
		else $error("register access served in hardware suspend");
endmodule : cpp_link_assertions

// ===== tb_top.sv
// bench for the host and accelerator pin control pair, driven over avalon
`timescale 1ns/10ps
module tb_top;
	import cpp_pkg::*;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic dev_rstn;
	logic mem_syn = 1'b1, vid_syn = 1'b1, sub_ref = 1'b1, sb_in = 1'b0;
	logic sh_in = 1'b0, bk_in = 1'b0, ext_mem = 1'b0, ext_vid = 1'b0;
	logic [3:0] pid = 4'ha;
	logic [1:0] av_addr = 2'h0;
	logic av_rd = 1'b0, av_wr = 1'b0, av_wait;
	logic [31:0] av_wd = 32'h0000_0000, av_q, q;
	logic [31:0] hb = 32'h0000_0000;
	logic mem_out, vid_out, syn_en, sub_out, enc, ss_out, bl_out, sb_out, sb_oe, lp, spread_ref;
	logic [1:0] oe_a;
	logic seen;
	int fail_count = 0;
	int n_compared = 0;
	int cycles = 0;
	int n;
	logic [3:0] rw_regs [5] = '{REG_PIN_FUNCTION, REG_SUBCARRIER_CONFIG, REG_BUS_FEATURE,
		REG_GENERAL_OUTPUT, REG_PIN_DIRECTION};
	// general output value, shift and backlight inputs, expected shift and backlight outputs
	logic [11:0] gp_tab [5] = '{12'h00a, 12'h017, 12'h02d, 12'h04b, 12'h084};
	cpp_link_if link ();
	wire [1:0] dev_oe = {link.memory_clock_pin_dev_oe, link.video_clock_pin_dev_oe};
	cpp_host cpp_host_inst (.CLOCK_IN(clock), .RSTN_IN(rstn), .LINK(link),
		.EXT_MEM_CLOCK_IN(ext_mem), .EXT_VID_CLOCK_IN(ext_vid), .AVS_ADDRESS_IN(av_addr),
		.AVS_READ_IN(av_rd), .AVS_WRITE_IN(av_wr), .AVS_WRITEDATA_IN(av_wd),
		.AVS_READDATA_OUT(av_q), .AVS_WAITREQUEST_OUT(av_wait), .DEVICE_RSTN_OUT(dev_rstn));
	cpp_device cpp_device_inst (.CLOCK_IN(clock), .RSTN_IN(dev_rstn), .LINK(link),
		.MEM_SYNTH_CLOCK_IN(mem_syn), .VID_SYNTH_CLOCK_IN(vid_syn), .SUBCARRIER_REF_IN(sub_ref),
		.PANEL_ID_PINS_IN(pid), .STANDBY_PIN_IN(sb_in), .SHIFT_CLOCK_IN(sh_in),
		.BACKLIGHT_POWER_IN(bk_in), .MEM_CLOCK_OUT(mem_out), .VID_CLOCK_OUT(vid_out),
		.SYNTH_ENABLE_OUT(syn_en), .SUBCARRIER_OUT(sub_out), .ENCODING_SELECT_OUT(enc),
		.SECOND_SHIFT_CLOCK_OUT(ss_out), .BACKLIGHT_CONTROL_OUT(bl_out),
		.STANDBY_PIN_OUT(sb_out), .STANDBY_PIN_OE_OUT(sb_oe), .LOW_POWER_OUT(lp),
		.SPREAD_REFERENCE_OUT(spread_ref));
	cpp_link_assertions cpp_link_assertions_inst (.clock_in(clock), .rstn_in(dev_rstn),
		.clock_source_select(link.clock_source_select), .suspend_dev_oe(link.suspend_dev_oe),
		.suspend_line(link.suspend_line), .bus_request_n_o(link.bus_request_n_o),
		.bus_request_n_oe(link.bus_request_n_oe), .interrupt_n_oe(link.interrupt_n_oe),
		.clkrun_dev_oe(link.clkrun_dev_oe), .clkrun_line(link.clkrun_line),
		.memory_clock_pin_host_oe(link.memory_clock_pin_host_oe),
		.video_clock_pin_host_oe(link.video_clock_pin_host_oe),
		.memory_clock_pin_dev_oe(link.memory_clock_pin_dev_oe),
		.video_clock_pin_dev_oe(link.video_clock_pin_dev_oe), .reg_sel(link.reg_sel),
		.reg_done(link.reg_done));
	always #5 clock = ~clock;
	// cut a hang short; the full run needs under a thousand cycles
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			stop_test();
		end
	end
	task automatic stop_test();
		if (fail_count == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : stop_test
	task automatic check(input string what, input logic [31:0] seen_v, input logic [31:0] exp);
		n_compared++;
		if (seen_v !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, seen_v);
		end
	endtask : check
	// one avalon transfer; held until waitrequest is seen low at a rising edge
	task automatic xf(input logic wr, input logic [1:0] a, input logic [31:0] d);
		@(posedge clock);
		av_addr <= a;
		av_wd <= d;
		av_wr <= wr;
		av_rd <= !wr;
		do @(posedge clock); while (av_wait !== 1'b0);
		q = av_q;
		av_wr <= 1'b0;
		av_rd <= 1'b0;
	endtask : xf
	// host level bits ride along with every command word
	task automatic hs(input logic [31:0] b);
		hb = b;
		xf(1'b1, AV_CMD, b);
	endtask : hs
	task automatic idle();
		do xf(1'b0, AV_STATUS, 32'h0000_0000); while (q[4] !== 1'b0);
	endtask : idle
	// 0x30 is the go and write bits of the command word
	task automatic dw(input logic [3:0] r, input logic [7:0] v);
		xf(1'b1, AV_WDATA, {24'h00_0000, v});
		xf(1'b1, AV_CMD, hb | 32'h0000_0030 | 32'(r));
		idle();
	endtask : dw
	task automatic dr(input logic [3:0] r);
		xf(1'b1, AV_CMD, hb | 32'h0000_0020 | 32'(r));
		idle();
		xf(1'b0, AV_RDATA, 32'h0000_0000);
	endtask : dr
	task automatic settle();
		repeat (4) @(posedge clock);
	endtask : settle
	task automatic watch_clkrun();
		seen = 1'b0;
		repeat (8) @(posedge clock) seen |= link.clkrun_dev_oe;
	endtask : watch_clkrun
	task automatic count_toggles();
		logic last;
		n = 0;
		@(posedge clock);
		last = sub_out;
		repeat (32) begin
			@(posedge clock);
			if (sub_out !== last) n++;
			last = sub_out;
		end
	endtask : count_toggles
	// main sequence: reset, then each pin function in turn
	initial begin
		repeat (16) @(posedge clock);
		rstn <= 1'b1;
		while (dev_rstn !== 1'b1) @(posedge clock);
		settle();
		check("busreq_idle", {link.bus_request_n_o, link.interrupt_n_oe, lp}, 3'b100);
		foreach (rw_regs[i]) begin
			dr(rw_regs[i]);
			check("reset_value", q[7:0], RESET_BYTE);
		end
		dr(REG_PANEL_ID);
		check("panel_id", q[3:0], 4'ha);
		pid <= 4'h5;
		dw(REG_PIN_FUNCTION, 8'h08);
		dr(REG_PANEL_ID);
		check("panel_id_sampled", q[3:0], 4'h5);
		// each clock pin switches role with its pin function bit
		dw(REG_PIN_FUNCTION, 8'h03);
		oe_a = dev_oe;
		dw(REG_PIN_FUNCTION, 8'h00);
		check("pin_roles", oe_a ^ dev_oe, 2'b11);
		check("internal", {syn_en, mem_out, vid_out}, 3'b111);
		hs(32'h1 << AV_CMD_XCLK_BIT);
		settle();
		check("external", {syn_en, mem_out, vid_out, dev_oe}, 5'b00000);
		dw(REG_PIN_FUNCTION, 8'h03);
		for (int i = 0; i < 2; i++) begin
			ext_mem <= i[0];
			ext_vid <= !i[0];
			settle();
			dr(REG_GENERAL_STATUS);
			check("status_pins", {q[GS_STATUS3_BIT], q[GS_STATUS4_BIT]}, {!i[0], i[0]});
		end
		hs(32'h0000_0000);
		dw(REG_PIN_FUNCTION, 8'h80);
		check("spread_pins", {dev_oe, mem_out, spread_ref}, 4'b0101);
		for (int i = 0; i < 2; i++) begin
			dw(REG_SUBCARRIER_CONFIG, 8'(i << SC_FOURX_BIT));
			count_toggles();
			check("subcarrier", n, i ? 32'h0000_0020 : 32'h0000_0008);
		end
		// divider stands still while the reference is low
		sub_ref <= 1'b0;
		settle();
		count_toggles();
		check("subcarrier_hold", n, 32'h0000_0000);
		sub_ref <= 1'b1;
		// clock run: no request while the host holds the line low
		hs(32'h1 << AV_CMD_HELD_BIT);
		dw(REG_BUS_FEATURE, 8'h20);
		dw(REG_CONTROL, 8'h20);
		watch_clkrun();
		check("clkrun_held", seen, 1'b0);
		hs(32'h0000_0000);
		watch_clkrun();
		check("clkrun_request", seen, 1'b1);
		dw(REG_BUS_FEATURE, 8'h00);
		watch_clkrun();
		check("clkrun_disabled", seen, 1'b0);
		dw(REG_CONTROL, 8'h1c);
		hs(32'h1 << AV_CMD_GRANT_BIT);
		settle();
		check("control_pins", {link.interrupt_n_oe, link.bus_request_n_o, enc}, 3'b101);
		dr(REG_CONTROL);
		check("grant_seen", {link.bus_grant_n, q[7:0]}, 9'h09c);
		dw(REG_CONTROL, 8'h00);
		hs(32'h0000_0000);
		check("control_clear", {link.interrupt_n_oe, link.bus_request_n_o, enc}, 3'b010);
		dw(REG_PIN_DIRECTION, 8'h08);
		dw(REG_CONTROL, 8'h01);
		dr(REG_POWER_STATUS);
		check("standby_out", {sb_oe, sb_out, q[PS_STANDBY_BIT]}, 3'b111);
		dw(REG_CONTROL, 8'h00);
		dw(REG_PIN_DIRECTION, 8'h10);
		dw(REG_CONTROL, 8'h02);
		check("sw_suspend", {link.suspend_dev_oe, link.suspend_dev_o, lp}, 3'b110);
		dw(REG_CONTROL, 8'h00);
		dw(REG_PIN_DIRECTION, 8'h00);
		dr(REG_POWER_STATUS);
		check("standby_in", {sb_oe, q[PS_STANDBY_BIT]}, 2'b00);
		foreach (gp_tab[i]) begin
			{sh_in, bk_in} <= gp_tab[i][3:2];
			dw(REG_GENERAL_OUTPUT, gp_tab[i][11:4]);
			check("general_out", {ss_out, bl_out}, gp_tab[i][1:0]);
		end
		// hardware suspend holds a write off until the host lets the pin go
		hs(32'h1 << AV_CMD_SUSPEND_BIT);
		settle();
		check("hw_suspend", lp, 1'b1);
		xf(1'b1, AV_WDATA, 32'h0000_0004);
		xf(1'b1, AV_CMD, hb | 32'h0000_0030 | 32'(REG_CONTROL));
		repeat (12) @(posedge clock);
		check("write_held", enc, 1'b0);
		// release the pin but keep the pending register write in the command word
		hs(32'h0000_0030 | 32'(REG_CONTROL));
		idle();
		check("resumed", {lp, enc}, 2'b01);
		stop_test();
	end
endmodule : tb_top
